// File: core/led_latch_pkg.sv
package led_latch_pkg;

    // Shift register and data latch geometry
    localparam int SHIFT_BITS = 224;
    localparam int LATCH_BITS = 218;
    localparam int CMD_BITS = 6;
    localparam logic [5:0] WRITE_CMD = 6'h25;

    // Latch field positions
    localparam int GRAY_BITS = 16;
    localparam int BRIGHT_BITS = 7;
    localparam int TRIPLETS = 4;
    localparam int GRAY_RED_0_LSB = 0;
    localparam int GRAY_GREEN_0_LSB = 16;
    localparam int GRAY_BLUE_0_LSB = 32;
    localparam int TRIPLET_STRIDE = 48;
    localparam int BRIGHT_RED_LSB = 192;
    localparam int BRIGHT_GREEN_LSB = 199;
    localparam int BRIGHT_BLUE_LSB = 206;
    localparam int BLANK_BIT = 213;
    localparam int REPEAT_BIT = 214;
    localparam int TIMING_RESET_BIT = 215;
    localparam int SERIAL_GS_CLOCK_BIT = 216;
    localparam int RISING_EDGE_BIT = 217;
    localparam logic BLANK_RESET = 1'b1;

    // Idle time before the latch pulse, as a multiple of the last edge interval
    localparam int IDLE_MULT_SHIFT = 3;

    // Register map (byte addresses)
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] LATCH_WIN_ADDR = 8'h40;
    localparam int LATCH_WORDS = 7;
    localparam logic CTRL_SERIAL_EN_RESET = 1'b1;
    localparam int CTRL_SERIAL_EN_BIT = 0;
    localparam int STATUS_BLANK_BIT = 0;
    localparam int STATUS_PREFIX_BIT = 1;
    localparam int STATUS_COUNT_LSB = 8;
    localparam logic [7:0] LOAD_COUNT_RESET = 8'h00;

    typedef struct packed {
        logic [GRAY_BITS-1:0] blue;
        logic [GRAY_BITS-1:0] green;
        logic [GRAY_BITS-1:0] red;
    } gray_triplet_t;

    typedef struct packed {
        logic [BRIGHT_BITS-1:0] blue;
        logic [BRIGHT_BITS-1:0] green;
        logic [BRIGHT_BITS-1:0] red;
    } bright_group_t;

    typedef struct packed {
        logic rising_edge_timing;
        logic serial_gs_clock;
        logic timing_reset;
        logic repeat_enable;
        logic outputs_blank;
    } function_control_t;

endpackage

// File: core/latch_pulse_timer.sv
module latch_pulse_timer
    import led_latch_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic edge_in,
    output logic fire_out
);
    logic [CNT_W-1:0] since;
    logic [CNT_W-1:0] interval;
    logic armed;
    logic [CNT_W+IDLE_MULT_SHIFT-1:0] target;

    assign target = {interval, {IDLE_MULT_SHIFT{1'b0}}};
    // Gap longer than the counter range saturates and never fires; size CNT_W to the link
    assign fire_out = armed && !edge_in && (interval != '0) &&
                      ({{IDLE_MULT_SHIFT{1'b0}}, since} == target);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            since <= '0;
        end else if (edge_in) begin
            since <= {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (since != '0 && since != '1) begin
            since <= since + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            interval <= '0;
            armed <= 1'b0;
        end else if (edge_in) begin
            interval <= since;
            armed <= 1'b1;
        end else if (fire_out) begin
            armed <= 1'b0;
        end
    end

    a_fire_once: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        fire_out |=> !fire_out ##1 !fire_out)
        else $error("latch pulse repeated without new edge");

endmodule // latch_pulse_timer

// File: core/led_driver_control_data_latch.sv
// Added by the designer: the Wishbone interface to the registers and the register offsets.
module led_driver_control_data_latch
    import led_latch_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output gray_triplet_t [TRIPLETS-1:0] grayscale_out,
    output bright_group_t brightness_control_out,
    output function_control_t function_control_out,
    output logic channels_off_out,
    output logic pwm_reset_out,
    output logic latch_pulse_out
);
    logic [SHIFT_BITS-1:0] shift;
    logic [LATCH_BITS-1:0] latch;
    logic [BLANK_BIT-1:0] latch_low;
    logic [LATCH_BITS-1:BLANK_BIT+1] latch_high;
    logic blank_flag;
    logic clock_prev;
    logic serial_edge;
    logic idle_fire;
    logic prefix_ok;
    logic latch_pulse;
    logic serial_en;
    logic [7:0] load_count;
    logic [31:0] next_rdata;

    function automatic logic [31:0] latch_word(input logic [LATCH_BITS-1:0] l,
                                               input int idx);
        logic [LATCH_WORDS*32-1:0] wide;
        wide = '0;
        wide[LATCH_BITS-1:0] = l;
        return wide[idx*32 +: 32];
    endfunction

    // Serial side: the input is already synchronous, one flop finds the rising edge
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            clock_prev <= 1'b0;
        end else begin
            clock_prev <= serial_clock_in;
        end
    end

    assign serial_edge = serial_en && serial_clock_in && !clock_prev;

    // Shift register has no defined power-up contents
    always_ff @(posedge ref_clk_in) begin
        if (serial_edge) begin
            shift <= {shift[SHIFT_BITS-2:0], serial_data_in};
        end
    end

    assign serial_data_out = shift[SHIFT_BITS-1];

    latch_pulse_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .edge_in(serial_edge),
        .fire_out(idle_fire)
    );

    assign prefix_ok = (shift[SHIFT_BITS-1 -: CMD_BITS] == WRITE_CMD);
    assign latch_pulse = idle_fire && prefix_ok;
    assign latch_pulse_out = latch_pulse;

    // Data bits carry no reset, only the blank flag does; kept apart so each has one driver
    always_ff @(posedge ref_clk_in) begin
        if (latch_pulse) begin
            latch_low <= shift[BLANK_BIT-1:0];
            latch_high <= shift[LATCH_BITS-1:BLANK_BIT+1];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            blank_flag <= BLANK_RESET;
        end else if (latch_pulse) begin
            blank_flag <= shift[BLANK_BIT];
        end
    end

    assign latch = {latch_high, blank_flag, latch_low};

    // Field decode
    for (genvar t = 0; t < TRIPLETS; t++) begin : g_triplet
        assign grayscale_out[t].red =
            latch[GRAY_RED_0_LSB + t*TRIPLET_STRIDE +: GRAY_BITS];
        assign grayscale_out[t].green =
            latch[GRAY_GREEN_0_LSB + t*TRIPLET_STRIDE +: GRAY_BITS];
        assign grayscale_out[t].blue =
            latch[GRAY_BLUE_0_LSB + t*TRIPLET_STRIDE +: GRAY_BITS];
    end

    assign brightness_control_out.red = latch[BRIGHT_RED_LSB +: BRIGHT_BITS];
    assign brightness_control_out.green = latch[BRIGHT_GREEN_LSB +: BRIGHT_BITS];
    assign brightness_control_out.blue = latch[BRIGHT_BLUE_LSB +: BRIGHT_BITS];
    assign function_control_out.outputs_blank = latch[BLANK_BIT];
    assign function_control_out.repeat_enable = latch[REPEAT_BIT];
    assign function_control_out.timing_reset = latch[TIMING_RESET_BIT];
    assign function_control_out.serial_gs_clock = latch[SERIAL_GS_CLOCK_BIT];
    assign function_control_out.rising_edge_timing = latch[RISING_EDGE_BIT];

    // PWM logic downstream clears its counter and timing while these are high
    assign channels_off_out = latch[BLANK_BIT];
    assign pwm_reset_out = latch[BLANK_BIT];

    // Wishbone slave: answer one cycle after the request, drop ack the cycle after
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
        end
    end

    // Write lands on the edge that also sees ack, where the master still holds the request
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_en <= CTRL_SERIAL_EN_RESET;
        end else if (wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out &&
                     wb_adr_in == CTRL_ADDR && wb_sel_in[0]) begin
            serial_en <= wb_dat_in[CTRL_SERIAL_EN_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            load_count <= LOAD_COUNT_RESET;
        end else if (latch_pulse) begin
            load_count <= load_count + 8'h01;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (wb_adr_in == CTRL_ADDR) begin
            next_rdata[CTRL_SERIAL_EN_BIT] = serial_en;
        end else if (wb_adr_in == STATUS_ADDR) begin
            next_rdata[STATUS_BLANK_BIT] = latch[BLANK_BIT];
            next_rdata[STATUS_PREFIX_BIT] = prefix_ok;
            next_rdata[STATUS_COUNT_LSB +: 8] = load_count;
        end else begin
            for (int i = 0; i < LATCH_WORDS; i++) begin
                if (wb_adr_in == LATCH_WIN_ADDR + 8'(i*4)) begin
                    next_rdata = latch_word(latch, i);
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (wb_cyc_in && wb_stb_in && !wb_ack_out) begin
            wb_dat_out <= next_rdata;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    a_latch_load: assert property (latch_pulse |=> latch == $past(shift[LATCH_BITS-1:0]))
        else $error("latch did not take shift register bits");

    a_blank_powerup: assert property ($fell(rst_in) |-> channels_off_out)
        else $error("blank flag not set after reset");

    a_triplet0_map: assert property (latch_pulse |=>
        grayscale_out[0].blue == $past(shift[47:32]) && grayscale_out[0].red == $past(shift[15:0]))
        else $error("triplet 0 grayscale mismatch");

    a_triplet1_map: assert property (latch_pulse |=>
        grayscale_out[1].green == $past(shift[79:64]))
        else $error("triplet 1 grayscale mismatch");

    a_triplet2_map: assert property (latch_pulse |=>
        grayscale_out[2].blue == $past(shift[143:128]))
        else $error("triplet 2 grayscale mismatch");

    a_triplet3_map: assert property (latch_pulse |=>
        grayscale_out[3].red == $past(shift[159:144]))
        else $error("triplet 3 grayscale mismatch");

    a_bright_red: assert property (latch_pulse |=>
        brightness_control_out.red == $past(shift[198:192]))
        else $error("red brightness mismatch");

    a_bright_gb: assert property (latch_pulse |=>
        brightness_control_out.green == $past(shift[205:199]) &&
        brightness_control_out.blue == $past(shift[212:206]))
        else $error("green or blue brightness mismatch");

    a_prefix_gate: assert property (idle_fire && !prefix_ok |=> $stable(latch))
        else $error("latch changed without write command");

    a_hold_stable: assert property (!latch_pulse |=> $stable(latch))
        else $error("latch changed between pulses");

    a_blank_off: assert property (latch_pulse && shift[BLANK_BIT] |=>
        channels_off_out && pwm_reset_out)
        else $error("blank did not force outputs off");

endmodule // led_driver_control_data_latch

// File: verification/serial_host_model.sv
module serial_host_model (
    input wire logic clk_in,
    output logic sck_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sck_out = 1'b0;
        sda_out = 1'b0;
    end

    // Clock stands low between frames; data turns over so a stale bit is never trusted
    task automatic send(input logic [223:0] pkt, input int half);
        for (int i = 223; i >= 0; i--) begin
            @(posedge clk_in);
            sck_out <= 1'b0;
            sda_out <= pkt[i];
            repeat (half) @(posedge clk_in);
            sck_out <= 1'b1;
            repeat (half - 1) @(posedge clk_in);
        end
        @(posedge clk_in);
        sck_out <= 1'b0;
        sda_out <= ~pkt[0];
    endtask
endmodule // serial_host_model

// File: verification/led_driver_control_data_latch_tb.sv
module led_driver_control_data_latch_tb import led_latch_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 2;
    logic clk, rst, cyc, stb, we, ack, off, pwr, pls, sdo;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dw, dr, q;
    wire logic sck, sda;
    gray_triplet_t [TRIPLETS-1:0] gray;
    bright_group_t brt;
    function_control_t fc;
    logic [223:0] cur;
    int err_total, comparisons;

    led_driver_control_data_latch #(.CNT_W(8)) led_driver_control_data_latch_i (
        .ref_clk_in(clk), .rst_in(rst), .serial_clock_in(sck), .serial_data_in(sda),
        .serial_data_out(sdo), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw), .wb_dat_out(dr),
        .wb_ack_out(ack), .grayscale_out(gray), .brightness_control_out(brt),
        .function_control_out(fc), .channels_off_out(off), .pwm_reset_out(pwr),
        .latch_pulse_out(pls));
    serial_host_model serial_host_model_i (.clk_in(clk), .sck_out(sck), .sda_out(sda));

    always #5 clk = ~clk;

    task automatic stop_test();
        $display("err_total %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dw <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            err_total++;
            $display("[ERR] %0t wishbone ack timeout", $time);
            stop_test();
        end
    endtask

    function automatic logic [223:0] mk(input logic [5:0] cmd, input logic blank);
        logic [223:0] p;
        p = '0;
        p[223:218] = cmd;
        for (int t = 0; t < 4; t++) begin
            for (int c = 0; c < 3; c++) begin
                p[48*t+16*c +: 16] = {4'(t), 4'(c), 8'hA5};
            end
        end
        p[212:192] = {7'h55, 7'h2A, 7'h11};
        p[217:213] = {4'hB, blank};
        return p;
    endfunction

    task automatic t_reset();
        chk(48'({off, pwr}), 48'h3);
        wb(1'b0, 8'h04, 32'h0);
        chk(48'(q[0]), 48'h1);
        wb(1'b0, 8'h20, 32'h0);
        chk(48'(q), 48'h0);
    endtask

    task automatic t_load(input logic [5:0] cmd, input logic blank, input logic ok);
        logic [223:0] p;
        int n;
        p = mk(cmd, blank);
        serial_host_model_i.send(p, HALF);
        chk(48'(sdo), 48'(p[223]));
        n = 0;
        while (pls !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (ok) begin
            // Window of two cycles either side is tighter than a 7x or 9x slip
            chk(48'(n >= 29 && n <= 33), 48'h1);
            cur = p;
        end else begin
            chk(48'(n), 48'h3C);
        end
        @(posedge clk);
        for (int t = 0; t < 4; t++) begin
            chk(48'(gray[t]), cur[48*t +: 48]);
        end
        chk(48'(brt), 48'(cur[212:192]));
        chk(48'(fc), 48'(cur[217:213]));
        chk(48'({off, pwr}), 48'({2{cur[213]}}));
    endtask

    task automatic t_readback();
        wb(1'b0, 8'h40, 32'h0);
        chk(48'(q), 48'(cur[31:0]));
        wb(1'b0, 8'h58, 32'h0);
        chk(48'(q), 48'(cur[217:192]));
        wb(1'b0, 8'h04, 32'h0);
        chk(48'(q[15:0]), 48'h0100);
    endtask

    task automatic t_serial_off();
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b0, 8'h00, 32'h0);
        chk(48'(q), 48'h0);
        t_load(6'h25, 1'b1, 1'b0);
        wb(1'b1, 8'h00, 32'h1);
    endtask

    task automatic t_reblank();
        t_load(6'h25, 1'b1, 1'b1);
        wb(1'b0, 8'h04, 32'h0);
        chk(48'(q[15:0]), 48'h0203);
    endtask

    initial begin
        {clk, cyc, stb, we} = '0;
        rst = 1'b1;
        adr = 8'h00;
        sel = 4'h0;
        dw = 32'h0;
        err_total = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        // Valid data goes out in the same frame that drops blank
        t_load(6'h25, 1'b0, 1'b1);
        t_load(6'h24, 1'b1, 1'b0);
        t_readback();
        t_serial_off();
        t_reblank();
        stop_test();
    end
endmodule // led_driver_control_data_latch_tb
